// ### accel_buffer_dev.sv
// Device end: axis output bytes, 32-entry sample buffer, buffer status and tap status
`timescale 1ns/100ps
module accel_buffer_dev
    import accel_pkg::*;
#(
    parameter int DEPTH_P = DEPTH
) (
    input wire logic aclk,
    input wire logic aresetn,
    accel_link_if.device link,
    input wire logic sample_valid,
    input wire logic [47:0] sample_data,
    input wire logic first_interrupt_pin,
    input wire logic second_interrupt_pin,
    input wire logic tap_event,
    input wire logic [2:0] tap_first_axes,
    input wire logic [2:0] tap_negative
);
    localparam int PW = $clog2(DEPTH_P);
    localparam int CW = $clog2(DEPTH_P + 1);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
        logic [7:0] buf_ctrl;
        logic [7:0] tilt_cfg;
        logic [7:0] tap_axes;
        logic [7:0] power;
        logic [47:0] out_stage;
        logic out_full;
        logic [PW-1:0] rd_ptr;
        logic [PW-1:0] wr_ptr;
        logic [CW-1:0] count;
        logic trig_seen;
        logic watermark;
        logic data_ready;
        logic [2:0] tap_sign;
        logic [2:0] tap_axis;
        logic pop_pending;
    } state_t;

    state_t s_r, s_nxt;
    logic [47:0] mem [DEPTH_P];

    function automatic logic is_axis_addr(input logic [7:0] a);
        return a >= ADDR_X_LOW && a <= ADDR_Z_HIGH;
    endfunction

    function automatic logic [7:0] axis_byte(input logic [47:0] d, input logic [7:0] a);
        logic [2:0] i;
        i = 3'(a - ADDR_X_LOW);
        return d[i*8 +: 8];
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    buf_mode_t mode;
    logic [4:0] wm_count;
    logic store, drop_oldest, pop, trig_pin, mem_wr;
    logic [47:0] head;

    always_comb begin
        s_nxt = s_r;
        mode = buf_mode_t'(s_r.buf_ctrl[MODE_HI:MODE_LO]);
        wm_count = s_r.buf_ctrl[COUNT_HI:0];
        trig_pin = s_r.buf_ctrl[TRIG_SRC_BIT] ? second_interrupt_pin
            : first_interrupt_pin;
        head = mem[s_r.rd_ptr];
        store = 1'b0;
        drop_oldest = 1'b0;
        mem_wr = 1'b0;
        pop = 1'b0;
        s_nxt.ack = 1'b0;

        // Register access; read data is the value before this cycle's pop
        if (link.req && !s_r.ack) begin
            s_nxt.ack = 1'b1;
            if (link.wr) begin
                unique case (link.addr)
                    ADDR_BUF_CTRL: begin
                        s_nxt.buf_ctrl = link.wdata;
                        if (link.wdata[MODE_HI:MODE_LO] != s_r.buf_ctrl[MODE_HI:MODE_LO])
                            s_nxt.trig_seen = 1'b0;
                    end
                    ADDR_TILT_CFG: s_nxt.tilt_cfg = link.wdata;
                    ADDR_TAP_AXES: s_nxt.tap_axes = link.wdata;
                    ADDR_POWER: s_nxt.power = link.wdata;
                    default: ;
                endcase
            end else begin
                if (is_axis_addr(link.addr)) begin
                    s_nxt.rdata = axis_byte(s_r.out_stage, link.addr);
                    // Pop once per access: at burst end, or at a lone single-byte read
                    if (!link.burst)
                        s_nxt.pop_pending = 1'b1;
                end else begin
                    unique case (link.addr)
                        ADDR_BUF_CTRL: s_nxt.rdata = s_r.buf_ctrl;
                        ADDR_BUF_STATUS: s_nxt.rdata = {s_r.trig_seen, 1'b0,
                            6'(s_r.count + CW'(s_r.out_full))};
                        ADDR_TAP_STATUS: s_nxt.rdata = {1'b0, s_r.tap_sign, 1'b0,
                            s_r.tap_axis};
                        ADDR_TILT_CFG: s_nxt.rdata = s_r.tilt_cfg;
                        ADDR_TAP_AXES: s_nxt.rdata = s_r.tap_axes;
                        ADDR_POWER: s_nxt.rdata = s_r.power;
                        ADDR_EVENT_SRC: s_nxt.rdata = {s_r.data_ready, 5'h00,
                            s_r.watermark, 1'b0};
                        default: s_nxt.rdata = 8'h00;
                    endcase
                end
            end
        end

        if (s_r.pop_pending) begin
            pop = 1'b1;
            s_nxt.pop_pending = 1'b0;
            s_nxt.data_ready = 1'b0;
        end

        // Output stage refills from the buffer head after a pop
        if (pop) begin
            if (mode != MODE_BYPASS && s_r.count != '0) begin
                s_nxt.out_stage = head;
                s_nxt.rd_ptr = PW'(s_r.rd_ptr + 1'b1);
                s_nxt.count = CW'(s_r.count - 1'b1);
            end else begin
                s_nxt.out_full = 1'b0;
            end
        end

        // Trigger event latches once while in trigger mode
        if (mode == MODE_TRIGGER && trig_pin)
            s_nxt.trig_seen = 1'b1;

        // New sample; sleep stops buffer writes and data-ready
        if (sample_valid && !s_r.power[SLEEP_BIT]) begin
            s_nxt.data_ready = 1'b1;
            unique case (mode)
                MODE_BYPASS: begin
                    s_nxt.out_stage = sample_data;
                    s_nxt.out_full = 1'b1;
                end
                MODE_FIFO: store = s_nxt.count < CW'(DEPTH_P);
                MODE_STREAM: begin
                    store = 1'b1;
                    drop_oldest = s_nxt.count == CW'(DEPTH_P);
                end
                MODE_TRIGGER: begin
                    if (s_r.trig_seen) begin
                        store = s_nxt.count < CW'(DEPTH_P);
                    end else begin
                        store = 1'b1;
                        drop_oldest = s_nxt.count >= CW'(wm_count);
                    end
                end
            endcase
            if (store && !s_nxt.out_full && s_nxt.count == '0 && mode != MODE_BYPASS) begin
                s_nxt.out_stage = sample_data;
                s_nxt.out_full = 1'b1;
            end else if (store) begin
                mem_wr = 1'b1;
                s_nxt.wr_ptr = PW'(s_r.wr_ptr + 1'b1);
                if (drop_oldest)
                    s_nxt.rd_ptr = PW'(s_nxt.rd_ptr + 1'b1);
                else
                    s_nxt.count = CW'(s_nxt.count + 1'b1);
            end
        end else if (s_r.power[SLEEP_BIT]) begin
            s_nxt.data_ready = 1'b0;
        end

        // Watermark: level flag recomputed every cycle, from the count in FIFO and stream modes, else 0 unless the watermark field is 0; no clear-by-read
        if (wm_count == '0)
            s_nxt.watermark = 1'b1;
        else if (mode == MODE_FIFO || mode == MODE_STREAM)
            s_nxt.watermark = s_nxt.count >= CW'(wm_count);
        else
            s_nxt.watermark = 1'b0;

        // Tap capture on enabled axes; disabled axes have their axis bit cleared, sign bit kept
        if (tap_event) begin
            for (int i = 0; i < 3; i++) begin
                if (s_r.tap_axes[i]) begin
                    s_nxt.tap_sign[i] = tap_negative[i];
                    s_nxt.tap_axis[i] = tap_first_axes[i];
                end else begin
                    s_nxt.tap_axis[i] = 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.buf_ctrl <= BUF_CTRL_RESET;
            s_r.tilt_cfg <= TILT_CFG_RESET;
            s_r.tap_axes <= TAP_AXES_RESET;
            s_r.power <= POWER_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (mem_wr)
            mem[s_r.wr_ptr] <= sample_data;
    end

    assign link.ack = s_r.ack;
    assign link.rdata = s_r.rdata;
endmodule

// ### accel_host.sv
// Host end: AXI4-Lite command registers driving burst reads of the sensor registers
`timescale 1ns/100ps
module accel_host
    import accel_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    accel_link_if.host link,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);
    // ----------------------------------------------------------------
    // Own registers
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {IDLE, ISSUE, WAIT} hstate_t;
    typedef struct packed {
        hstate_t st;
        logic aw_got, w_got, bvalid, rvalid, awready, wready, arready;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [31:0] rdata;
        logic [31:0] cmd;
        logic busy;
        logic [2:0] idx;
        logic [2:0] len;
        logic [47:0] data;
        logic req, wr, burst;
        logic [7:0] addr, wdat;
    } state_t;

    state_t s_r, s_nxt;

    function automatic logic [31:0] read_reg(input state_t s, input logic [7:0] a);
        unique case (a)
            CMD_OFF: return s.cmd;
            STAT_OFF: return {31'h0000_0000, s.busy};
            DATA_LO_OFF: return s.data[31:0];
            DATA_HI_OFF: return {16'h0000, s.data[47:32]};
            default: return 32'h0000_0000;
        endcase
    endfunction

    always_comb begin
        s_nxt = s_r;
        s_nxt.awready = 1'b0;
        s_nxt.wready = 1'b0;
        s_nxt.arready = 1'b0;
        if (awvalid && !s_r.aw_got && !s_r.awready) begin
            s_nxt.awready = 1'b1;
            s_nxt.aw_got = 1'b1;
            s_nxt.aw_addr = awaddr;
        end
        if (wvalid && !s_r.w_got && !s_r.wready) begin
            s_nxt.wready = 1'b1;
            s_nxt.w_got = 1'b1;
            s_nxt.w_data = wdata;
        end
        if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
            s_nxt.bvalid = 1'b1;
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            if (s_r.aw_addr == CMD_OFF && !s_r.busy && wstrb != 4'h0) begin
                // cmd: [7:0] addr, [15:8] wdata, bit16 write, [19:17] length
                s_nxt.cmd = s_r.w_data;
                s_nxt.busy = 1'b1;
                s_nxt.st = ISSUE;
                s_nxt.idx = 3'h0;
                s_nxt.len = s_r.w_data[19:17] == 3'h0 ? 3'h1 : s_r.w_data[19:17];
                s_nxt.addr = s_r.w_data[7:0];
            end
        end
        if (s_r.bvalid && bready)
            s_nxt.bvalid = 1'b0;
        if (arvalid && !s_r.rvalid && !s_r.arready) begin
            s_nxt.arready = 1'b1;
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = read_reg(s_r, araddr);
        end
        if (s_r.rvalid && rready)
            s_nxt.rvalid = 1'b0;

        // Link sequencer: one byte per handshake, burst held across bytes
        unique case (s_r.st)
            IDLE: s_nxt.req = 1'b0;
            ISSUE: begin
                s_nxt.req = 1'b1;
                s_nxt.wr = s_r.cmd[16];
                s_nxt.wdat = s_r.cmd[15:8];
                s_nxt.burst = 3'(s_r.idx + 1'b1) < s_r.len;
                s_nxt.st = WAIT;
            end
            WAIT: begin
                if (link.ack) begin
                    s_nxt.req = 1'b0;
                    s_nxt.data[s_r.idx*8 +: 8] = link.rdata;
                    s_nxt.idx = 3'(s_r.idx + 1'b1);
                    s_nxt.addr = 8'(s_r.addr + 1'b1);
                    if (3'(s_r.idx + 1'b1) >= s_r.len) begin
                        s_nxt.st = IDLE;
                        s_nxt.busy = 1'b0;
                    end else begin
                        s_nxt.st = ISSUE;
                    end
                end
            end
            default: s_nxt.st = IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign awready = s_r.awready;
    assign wready = s_r.wready;
    assign bvalid = s_r.bvalid;
    assign bresp = 2'b00;
    assign arready = s_r.arready;
    assign rvalid = s_r.rvalid;
    assign rdata = s_r.rdata;
    assign rresp = 2'b00;
    assign link.req = s_r.req;
    assign link.wr = s_r.wr;
    assign link.burst = s_r.burst;
    assign link.addr = s_r.addr;
    assign link.wdata = s_r.wdat;
endmodule

// ### accel_link_if.sv
// Interface: byte register port between sensor buffer stage and host
`timescale 1ns/100ps
interface accel_link_if;
    logic req;
    logic wr;
    logic burst;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic ack;
    logic [7:0] rdata;
    modport device (input req, input wr, input burst, input addr, input wdata,
        output ack, output rdata);
    modport host (output req, output wr, output burst, output addr, output wdata,
        input ack, input rdata);
endinterface

// ### accel_link_props.sv
// Checker: concurrent properties on the byte link between host and device ends
`timescale 1ns/100ps
module accel_link_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req,
    input wire logic wr,
    input wire logic burst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic ack,
    input wire logic [7:0] rdata
);
    // ------------------------------------------------------------
    // Helper
    // ------------------------------------------------------------
    // Address of the last answered byte, so a burst step is checked across the idle gap
    logic [7:0] last_addr_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_addr_r <= 8'h00;
        end else if (ack) begin
            last_addr_r <= addr;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    AST_ANSWER_NEXT: assert property (req && !ack |=> ack)
        else $error("link request not answered in one cycle");
    AST_ACK_PULSE: assert property (ack |=> !ack)
        else $error("link answer longer than one cycle");
    AST_ACK_CAUSE: assert property (ack |-> $past(req) && !$past(ack))
        else $error("link answer without a pending request");
    AST_REQ_RELEASE: assert property (ack |=> !req)
        else $error("request still up after its answer");
    AST_REQ_HOLD: assert property (req && !ack |=> $stable(addr) && $stable(wr) && $stable(burst))
        else $error("request qualifiers moved before the answer");
    AST_WDATA_HOLD: assert property (req && wr && !ack |=> $stable(wdata))
        else $error("write byte moved before the answer");
    AST_RDATA_HOLD: assert property ($changed(rdata) |-> ack)
        else $error("read byte changed outside an answer");
    AST_BURST_STEP: assert property (ack && burst && !wr |-> ##[2:3] (req && addr == last_addr_r + 8'h01))
        else $error("burst did not move to the next register");
endmodule

// ### accel_pkg.sv
// Package: register map, field layout and timing constants of the sensor buffer stage
package accel_pkg;
    localparam logic [7:0] ADDR_X_LOW = 8'h32;
    localparam logic [7:0] ADDR_X_HIGH = 8'h33;
    localparam logic [7:0] ADDR_Y_LOW = 8'h34;
    localparam logic [7:0] ADDR_Y_HIGH = 8'h35;
    localparam logic [7:0] ADDR_Z_LOW = 8'h36;
    localparam logic [7:0] ADDR_Z_HIGH = 8'h37;
    localparam logic [7:0] ADDR_BUF_CTRL = 8'h38;
    localparam logic [7:0] ADDR_BUF_STATUS = 8'h39;
    localparam logic [7:0] ADDR_TAP_STATUS = 8'h3a;
    localparam logic [7:0] ADDR_TILT_CFG = 8'h3b;
    localparam logic [7:0] ADDR_EVENT_SRC = 8'h30;
    localparam logic [7:0] ADDR_TAP_AXES = 8'h2a;
    localparam logic [7:0] ADDR_POWER = 8'h2d;
    // Host command registers on the AXI4-Lite side, one aligned word each
    localparam logic [7:0] CMD_OFF = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;
    localparam logic [7:0] DATA_LO_OFF = 8'h08;
    localparam logic [7:0] DATA_HI_OFF = 8'h0c;
    // Buffer control fields
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int TRIG_SRC_BIT = 5;
    localparam int COUNT_HI = 4;
    // Status fields, power sleep bit, buffer depth and reset values
    localparam int TRIG_SEEN_BIT = 7;
    localparam int WATERMARK_BIT = 1;
    localparam int DATA_READY_BIT = 7;
    localparam int SLEEP_BIT = 2;
    localparam int DEPTH = 32;
    localparam logic [7:0] BUF_CTRL_RESET = 8'h00;
    localparam logic [7:0] TILT_CFG_RESET = 8'h25;
    localparam logic [7:0] TAP_AXES_RESET = 8'h00;
    localparam logic [7:0] POWER_RESET = 8'h00;
    // Host poll interval in clock cycles (1 us at 25 MHz)
    localparam int POLL_NS = 1000;
    localparam int CLK_NS = 40;
    localparam int POLL_CYCLES = POLL_NS / CLK_NS;
    typedef enum logic [1:0] {MODE_BYPASS, MODE_FIFO, MODE_STREAM, MODE_TRIGGER} buf_mode_t;
endpackage

// ### tb.sv
// Testbench: host and device ends joined by the link, host driven over AXI4-Lite
`timescale 1ns/100ps
module tb;
    import accel_pkg::*;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic sample_valid, first_interrupt_pin, second_interrupt_pin, tap_event;
    logic [47:0] sample_data;
    logic [2:0] tap_first_axes, tap_negative;
    int num_errors, comparisons, cycles;

    accel_link_if link ();
    accel_buffer_dev u_accel_buffer_dev (.aclk(aclk), .aresetn(aresetn), .link(link),
        .sample_valid(sample_valid), .sample_data(sample_data),
        .first_interrupt_pin(first_interrupt_pin), .second_interrupt_pin(second_interrupt_pin),
        .tap_event(tap_event), .tap_first_axes(tap_first_axes), .tap_negative(tap_negative));
    accel_host u_accel_host (.aclk(aclk), .aresetn(aresetn), .link(link), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp));
    accel_link_props u_accel_link_props (.aclk(aclk), .aresetn(aresetn), .req(link.req),
        .wr(link.wr), .burst(link.burst), .addr(link.addr), .wdata(link.wdata),
        .ack(link.ack), .rdata(link.rdata));

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task close_out();
        $display("Mismatches %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Generous ceiling; the full sequence needs well under a tenth of it
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors++;
            close_out();
        end
    end

    task check(input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task axi_write(input logic [7:0] a, input logic [31:0] d);
        logic got_b;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        got_b = 1'b0;
        while (!got_b) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) got_b = 1'b1;
        end
        bready <= 1'b0;
    endtask

    task axi_read(input logic [7:0] a, output logic [31:0] d);
        logic got_r;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        got_r = 1'b0;
        while (!got_r) begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                got_r = 1'b1;
            end
        end
        rready <= 1'b0;
    endtask

    // Busy is polled with no count; a stuck link is caught by the ceiling above
    task link_op(input logic [2:0] len, input logic w, input logic [7:0] a, input logic [7:0] d);
        axi_write(CMD_OFF, {12'h000, len, w, d, a});
        v = 32'h0000_0001;
        while (v[0] !== 1'b0) axi_read(STAT_OFF, v);
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        link_op(3'd1, 1'b1, a, d);
    endtask

    task rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
        link_op(3'd1, 1'b0, a, 8'h00);
        axi_read(DATA_LO_OFF, v);
        check({40'h0, v[7:0] & m}, {40'h0, exp});
    endtask

    task rd6(input logic [47:0] exp);
        logic [31:0] lo;
        link_op(3'd6, 1'b0, ADDR_X_LOW, 8'h00);
        axi_read(DATA_LO_OFF, lo);
        axi_read(DATA_HI_OFF, v);
        check({v[15:0], lo}, exp);
    endtask

    function automatic logic [47:0] smp(input int i);
        logic [15:0] k;
        k = i[15:0];
        return {16'h3000 + k, 16'h2000 + k, 16'hf000 + k};
    endfunction

    task push(input int n, input int base);
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            sample_valid <= 1'b1;
            sample_data <= smp(base + i);
            @(posedge aclk);
            sample_valid <= 1'b0;
        end
    endtask

    task pin_pulse(input logic second);
        @(posedge aclk);
        if (second) second_interrupt_pin <= 1'b1;
        else first_interrupt_pin <= 1'b1;
        repeat (4) @(posedge aclk);
        first_interrupt_pin <= 1'b0;
        second_interrupt_pin <= 1'b0;
    endtask

    task tap(input logic [2:0] axes, input logic [2:0] neg);
        @(posedge aclk);
        tap_event <= 1'b1;
        tap_first_axes <= axes;
        tap_negative <= neg;
        @(posedge aclk);
        tap_event <= 1'b0;
    endtask

    task do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, sample_valid, tap_event} = 8'h00;
        {first_interrupt_pin, second_interrupt_pin} = 2'b00;
        {awaddr, araddr, wdata, sample_data} = 96'h0;
        {tap_first_axes, tap_negative} = 6'h00;
        wstrb = 4'hf;
        num_errors = 0;
        comparisons = 0;
        cycles = 0;
        do_reset();
        rd(ADDR_BUF_CTRL, BUF_CTRL_RESET, 8'hff);
        rd(ADDR_EVENT_SRC, 8'h02, 8'h02);
        push(1, 5);
        rd6(smp(5));
        wr(ADDR_X_LOW, 8'h5a);
        rd6(smp(5));
        wr(ADDR_BUF_CTRL, 8'h45);
        push(34, 0);
        rd(ADDR_BUF_STATUS, 8'h21, 8'hff);
        rd(ADDR_EVENT_SRC, 8'h82, 8'h82);
        rd6(smp(0));
        rd(ADDR_X_LOW, 8'h01, 8'hff);
        rd6(smp(2));
        rd(ADDR_BUF_STATUS, 8'h1e, 8'h3f);
        do_reset();
        wr(ADDR_POWER, 8'h04);
        wr(ADDR_BUF_CTRL, 8'h45);
        push(3, 0);
        rd(ADDR_BUF_STATUS, 8'h00, 8'h3f);
        rd(ADDR_EVENT_SRC, 8'h00, 8'h80);
        wr(ADDR_POWER, 8'h00);
        push(2, 0);
        rd(ADDR_BUF_STATUS, 8'h02, 8'h3f);
        rd(ADDR_EVENT_SRC, 8'h00, 8'h02);
        do_reset();
        wr(ADDR_BUF_CTRL, 8'h8a);
        rd(ADDR_EVENT_SRC, 8'h00, 8'h02);
        wr(ADDR_BUF_CTRL, 8'h80);
        rd(ADDR_EVENT_SRC, 8'h02, 8'h02);
        wr(ADDR_BUF_CTRL, 8'h85);
        push(40, 0);
        rd(ADDR_BUF_STATUS, 8'h21, 8'h3f);
        // Output stage keeps the first sample; overwrites only touch the stored 32
        rd6(smp(0));
        for (int k = 8; k < 40; k++) rd6(smp(k));
        rd(ADDR_BUF_STATUS, 8'h00, 8'h3f);
        do_reset();
        wr(ADDR_BUF_CTRL, 8'he3);
        push(10, 0);
        rd(ADDR_BUF_STATUS, 8'h04, 8'hff);
        pin_pulse(1'b0);
        rd(ADDR_BUF_STATUS, 8'h00, 8'h80);
        pin_pulse(1'b1);
        rd(ADDR_BUF_STATUS, 8'h80, 8'h80);
        push(40, 10);
        rd(ADDR_BUF_STATUS, 8'ha1, 8'hff);
        wr(ADDR_TAP_AXES, 8'h07);
        tap(3'b101, 3'b100);
        rd(ADDR_TAP_STATUS, 8'h45, 8'hff);
        wr(ADDR_TAP_AXES, 8'h03);
        tap(3'b011, 3'b011);
        rd(ADDR_TAP_STATUS, 8'h73, 8'hff);
        close_out();
    end
endmodule
